// [design/disc_parity_pkg.sv]
/*
  Constants for the disc link parity and error flag block.
  Assumes one 20 MHz clock domain and AXI4-Lite software access.
*/
package disc_parity_pkg;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          SETTLE_TIME_NS = 400;
  localparam int          SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ADDR_BITS      = 21;
  localparam int          WORD_BITS      = 37;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_CMDLOAD    = 8'h08;
  // control field positions
  localparam int          CMD_LSB        = 0;
  localparam int          EFE_BIT        = 2;
  localparam int          PIA_LSB        = 3;
  localparam int          CTRL_BITS      = 6;
  // status field positions
  localparam int          STAT_FER_BIT   = 0;
  localparam int          STAT_PER_BIT   = 1;
  localparam int          STAT_PAR_BIT   = 2;
  localparam int          STAT_PHASE_BIT = 3;
  localparam int          STAT_NOTOPR_BIT = 4;
  localparam logic [1:0]  CMD_NONE       = 2'h0;
  localparam logic [1:0]  CMD_RESET      = 2'h0;
  localparam logic [1:0]  AXI_OKAY       = 2'h0;
  localparam logic [1:0]  AXI_SLVERR     = 2'h2;
  typedef enum logic [1:0] {
    CMD_IDLE_C    = 2'b00,
    CMD_WRITE_C   = 2'b01,
    CMD_READ_C    = 2'b10,
    CMD_RDCMP_C   = 2'b11
  } cmd_code_t;
endpackage : disc_parity_pkg

// [design/disc_parity.sv]
/*
  Parity generation and checking, error flags and interrupt channel
  routing for the serial disc link. Assumes the sequencer supplies
  single-cycle write clocks and the link pulses are synchronous.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module disc_parity
  import disc_parity_pkg::*;
#(
  parameter int ADDR_LEN = ADDR_BITS,
  parameter int WORD_LEN = WORD_BITS
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // sequencer side
  input  wire logic        FRAME_CLEAR_PULSE,
  input  wire logic        STATUS_CLEAR_PULSE,
  input  wire logic        ODD_WRITE_CLOCK,
  input  wire logic        SHIFT_STEP_PULSE,
  input  wire logic        PHASE_SET_PULSE,
  input  wire logic        ADDRESS_SENDING_STATE,
  input  wire logic        WORDS_REMAINING_LEVEL,
  input  wire logic        ACCUMULATOR_OUT_BIT,
  output logic             DATA_CLOCK_CHAIN,
  output logic             READ_ZERO_PULSE,
  output logic             READ_ONE_PULSE,
  output logic             CLEAR_BIT_TWO,
  // disc link
  input  wire logic        ODD_ZEROS_IN,
  input  wire logic        ODD_ONES_IN,
  output logic             ODD_ZEROS_LINE_PULSE,
  output logic             ODD_ONES_LINE_PULSE,
  input  wire logic        UNIT_OPERABLE_LEVEL,
  // interrupt request lines 1..7, index 0 unused
  output logic [7:0]       IRQ_REQUEST_LINES
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] command_code_ff;
  logic       efe_ff;
  logic [2:0] irq_channel_assign_ff;
  logic       parity_accumulator_ff;
  logic       parity_phase_flag_ff;
  logic       file_error_flag_ff;
  logic       parity_error_flag_ff;
  logic [1:0] zeros_sync_ff;
  logic [1:0] ones_sync_ff;
  logic       zeros_prev_ff;
  logic       ones_prev_ff;
  logic       step2_pend_ff;
  logic [3:0] settle_cnt_ff;

  logic       reading;
  logic       write_level;
  logic       zeros_edge;
  logic       ones_edge;
  logic       read_zero;
  logic       read_one;
  logic       step2;
  logic       shift_data;
  logic       irq_request_level;
  logic       command_change_enable;

  assign reading     = command_code_ff[1];
  assign write_level = (command_code_ff == CMD_WRITE_C);

  ////////////////////////////////////////////////////////////////////////////
  // link input synchronisers and edge detect
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      zeros_sync_ff <= 2'h0;
      ones_sync_ff  <= 2'h0;
      zeros_prev_ff <= 1'b0;
      ones_prev_ff  <= 1'b0;
    end else begin
      zeros_sync_ff <= {zeros_sync_ff[0], ODD_ZEROS_IN};
      ones_sync_ff  <= {ones_sync_ff[0], ODD_ONES_IN};
      zeros_prev_ff <= zeros_sync_ff[1];
      ones_prev_ff  <= ones_sync_ff[1];
    end
  end

  assign zeros_edge = zeros_sync_ff[1] && !zeros_prev_ff;
  assign ones_edge  = ones_sync_ff[1] && !ones_prev_ff;
  assign read_zero  = zeros_edge && reading && WORDS_REMAINING_LEVEL;
  assign read_one   = ones_edge && reading && WORDS_REMAINING_LEVEL;

  always_comb begin
    READ_ZERO_PULSE  = read_zero;
    READ_ONE_PULSE   = read_one;
    DATA_CLOCK_CHAIN = read_zero || read_one;
    // read-compare keeps the bit
    CLEAR_BIT_TWO    = read_zero && (command_code_ff == CMD_READ_C);
  end

  ////////////////////////////////////////////////////////////////////////////
  // second clock step: on reads it follows the line pulse after the settle
  // delay so the accumulator has toggled first; on writes it follows the
  // sequencer's write clock after the same delay.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      step2_pend_ff <= 1'b0;
      settle_cnt_ff <= 4'h0;
    end else if (DATA_CLOCK_CHAIN || (ODD_WRITE_CLOCK && !reading)) begin
      step2_pend_ff <= 1'b1;
      settle_cnt_ff <= 4'(SETTLE_CYCLES - 1);
    end else if (step2_pend_ff && settle_cnt_ff != 4'h0) begin
      settle_cnt_ff <= settle_cnt_ff - 4'h1;
    end else begin
      step2_pend_ff <= 1'b0;
    end
  end

  assign step2      = (step2_pend_ff && settle_cnt_ff == 4'h0) || SHIFT_STEP_PULSE;
  assign shift_data = step2 && !parity_phase_flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  // parity phase: set at the step of the bit before parity
  always_ff @(posedge CLOCK) begin
    if (!RST_N || FRAME_CLEAR_PULSE) begin
      parity_phase_flag_ff <= 1'b0;
    end else if (step2 && parity_phase_flag_ff) begin
      parity_phase_flag_ff <= 1'b0;
    end else if (PHASE_SET_PULSE) begin
      parity_phase_flag_ff <= 1'b1;
    end
  end

  // parity accumulator
  always_ff @(posedge CLOCK) begin
    if (!RST_N || FRAME_CLEAR_PULSE) begin
      parity_accumulator_ff <= 1'b0;
    end else if (step2 && parity_phase_flag_ff) begin
      parity_accumulator_ff <= 1'b0;
    end else if (reading && read_one) begin
      parity_accumulator_ff <= !parity_accumulator_ff;
    end else if (shift_data && ACCUMULATOR_OUT_BIT
                 && (ADDRESS_SENDING_STATE || write_level)) begin
      parity_accumulator_ff <= !parity_accumulator_ff;
    end
  end

  // outgoing line pulses; parity bit is complement of accumulator
  always_comb begin
    ODD_ZEROS_LINE_PULSE = ODD_WRITE_CLOCK &&
      ((!parity_phase_flag_ff && !ACCUMULATOR_OUT_BIT) ||
       (parity_phase_flag_ff && parity_accumulator_ff));
    ODD_ONES_LINE_PULSE = ODD_WRITE_CLOCK &&
      ((!parity_phase_flag_ff && ACCUMULATOR_OUT_BIT) ||
       (parity_phase_flag_ff && !parity_accumulator_ff));
  end

  ////////////////////////////////////////////////////////////////////////////
  // error flags; set wins over the status clear
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      parity_error_flag_ff <= 1'b0;
    end else if (step2 && parity_phase_flag_ff && command_code_ff[1]
                 && !parity_accumulator_ff) begin
      parity_error_flag_ff <= 1'b1;
    end else if (STATUS_CLEAR_PULSE) begin
      parity_error_flag_ff <= 1'b0;
    end
  end

  // file error is a level from the unit; the register only holds it
  // once the unit recovers, so the flag shows without waiting a clock
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      file_error_flag_ff <= 1'b0;
    end else if (!UNIT_OPERABLE_LEVEL) begin
      file_error_flag_ff <= 1'b1;
    end else if (STATUS_CLEAR_PULSE) begin
      file_error_flag_ff <= 1'b0;
    end
  end

  logic file_error;
  assign file_error = file_error_flag_ff || !UNIT_OPERABLE_LEVEL;

  assign irq_request_level = efe_ff && (file_error || parity_error_flag_ff);

  // request line n low-true grounded: here driven high when asserted
  always_comb begin
    IRQ_REQUEST_LINES = 8'h00;
    if (irq_request_level && irq_channel_assign_ff != 3'h0) begin
      IRQ_REQUEST_LINES[irq_channel_assign_ff] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write taken when both address and data are present
  logic aw_ok;
  logic do_write;
  assign command_change_enable = UNIT_OPERABLE_LEVEL;
  assign aw_ok         = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign S_AXI_AWREADY = aw_ok;
  assign S_AXI_WREADY  = aw_ok;
  assign do_write      = aw_ok;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      command_code_ff       <= CMD_RESET;
      efe_ff                <= 1'b0;
      irq_channel_assign_ff <= 3'h0;
    end else if (do_write && S_AXI_AWADDR == REG_CMDLOAD && S_AXI_WSTRB[0]) begin
      efe_ff                <= S_AXI_WDATA[EFE_BIT];
      irq_channel_assign_ff <= S_AXI_WDATA[PIA_LSB +: 3];
      if (command_change_enable) begin
        command_code_ff <= S_AXI_WDATA[CMD_LSB +: 2];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= AXI_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (S_AXI_AWADDR == REG_CMDLOAD) ? AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= AXI_OKAY;
      S_AXI_RDATA  <= 32'h0;
      unique case (S_AXI_ARADDR)
        REG_CTRL, REG_CMDLOAD: begin
          S_AXI_RDATA[CTRL_BITS-1:0] <= {irq_channel_assign_ff, efe_ff, command_code_ff};
        end
        REG_STATUS: begin
          S_AXI_RDATA[STAT_FER_BIT]    <= file_error;
          S_AXI_RDATA[STAT_PER_BIT]    <= parity_error_flag_ff;
          S_AXI_RDATA[STAT_PAR_BIT]    <= parity_accumulator_ff;
          S_AXI_RDATA[STAT_PHASE_BIT]  <= parity_phase_flag_ff;
          S_AXI_RDATA[STAT_NOTOPR_BIT] <= !UNIT_OPERABLE_LEVEL;
        end
        default: begin
          S_AXI_RRESP <= AXI_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_RZ_CHAIN: assert property (@(posedge CLOCK) disable iff (!RST_N)
    READ_ZERO_PULSE |-> DATA_CLOCK_CHAIN && reading)
    else $error("read zero without chain");
  AST_BIT_TWO: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CLEAR_BIT_TWO |-> command_code_ff == CMD_READ_C)
    else $error("bit two cleared outside read");
  AST_PAR_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ODD_WRITE_CLOCK && parity_phase_flag_ff |->
      ODD_ZEROS_LINE_PULSE == parity_accumulator_ff)
    else $error("wrong parity bit");
  AST_ONEHOT: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ODD_WRITE_CLOCK |-> ODD_ZEROS_LINE_PULSE != ODD_ONES_LINE_PULSE)
    else $error("line pulses not exclusive");
  AST_FER: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !UNIT_OPERABLE_LEVEL |=> file_error_flag_ff)
    else $error("file error not set");
  AST_PER_STICKY: assert property (@(posedge CLOCK) disable iff (!RST_N)
    parity_error_flag_ff && !STATUS_CLEAR_PULSE |=> parity_error_flag_ff)
    else $error("parity error lost");
  AST_PER_SET: assert property (@(posedge CLOCK) disable iff (!RST_N)
    step2 && parity_phase_flag_ff && reading && !parity_accumulator_ff
      |=> parity_error_flag_ff)
    else $error("parity error missed");
  AST_NO_IRQ0: assert property (@(posedge CLOCK) disable iff (!RST_N)
    irq_channel_assign_ff == 3'h0 |-> IRQ_REQUEST_LINES == 8'h00)
    else $error("request without channel");
  AST_PAR_CLR: assert property (@(posedge CLOCK) disable iff (!RST_N)
    FRAME_CLEAR_PULSE |=> !parity_accumulator_ff && !parity_phase_flag_ff)
    else $error("frame clear ignored");

  ////////////////////////////////////////////////////////////////////////////
  // incoming pulses pass two sync stages and an edge detect first
  sequence ones_arrive_s;
    $rose(ones_sync_ff[1]) && reading && WORDS_REMAINING_LEVEL;
  endsequence
  sequence zeros_arrive_s;
    $rose(zeros_sync_ff[1]) && reading && WORDS_REMAINING_LEVEL;
  endsequence

  // a step start, then a quiet settle window before the second step
  sequence step_start_s;
    DATA_CLOCK_CHAIN || (ODD_WRITE_CLOCK && !reading);
  endsequence
  sequence settle_window_s;
    (!DATA_CLOCK_CHAIN && !(ODD_WRITE_CLOCK && !reading))[*7];
  endsequence

  AST_RO_CHAIN: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ones_arrive_s |-> READ_ONE_PULSE && DATA_CLOCK_CHAIN)
    else $error("read one pulse missing");
  AST_RZ_ARRIVE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    zeros_arrive_s |-> READ_ZERO_PULSE && DATA_CLOCK_CHAIN)
    else $error("read zero pulse missing");
  AST_STEP_DELAY: assert property (@(posedge CLOCK) disable iff (!RST_N)
    step_start_s ##1 settle_window_s |=> step2)
    else $error("second step not on time");
  AST_RO_TOGGLE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    READ_ONE_PULSE && !FRAME_CLEAR_PULSE && !(step2 && parity_phase_flag_ff)
      |=> parity_accumulator_ff != $past(parity_accumulator_ff))
    else $error("accumulator did not toggle");
  AST_CMD_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !UNIT_OPERABLE_LEVEL |=> $stable(command_code_ff))
    else $error("command changed while not operable");
  AST_IRQ_LINE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    irq_request_level && irq_channel_assign_ff != 3'h0
      |-> IRQ_REQUEST_LINES == (8'h01 << irq_channel_assign_ff))
    else $error("wrong request line");
  AST_PER_CLR: assert property (@(posedge CLOCK) disable iff (!RST_N)
    STATUS_CLEAR_PULSE
      && !(step2 && parity_phase_flag_ff && reading && !parity_accumulator_ff)
      |=> !parity_error_flag_ff)
    else $error("status clear ignored");
  AST_PHASE_SET: assert property (@(posedge CLOCK) disable iff (!RST_N)
    PHASE_SET_PULSE && !FRAME_CLEAR_PULSE && !(step2 && parity_phase_flag_ff)
      |=> parity_phase_flag_ff)
    else $error("parity phase not set");
  AST_PHASE_END: assert property (@(posedge CLOCK) disable iff (!RST_N)
    step2 && parity_phase_flag_ff
      |=> !parity_phase_flag_ff && !parity_accumulator_ff)
    else $error("parity step did not clear");

endmodule : disc_parity

// [sim/disc_unit_model.sv]
/*
  Disc unit stand-in: sends bits as single pulses on the odd line pair
  and collects the bits the controller transmits.
  Assumes it shares the controller clock; the lines idle low.
*/
`timescale 1ns/10ps
module disc_unit_model (
  // clock
  input  wire logic clk,
  // lines toward the controller
  output logic      zeros_out,
  output logic      ones_out,
  output logic      operable,
  // lines from the controller
  input  wire logic zeros_in,
  input  wire logic ones_in
);
  logic [63:0] rx_bits_ff;
  int          rx_count_ff;

  initial begin
    zeros_out   = 1'b0;
    ones_out    = 1'b0;
    operable    = 1'b1;
    rx_bits_ff  = 64'h0;
    rx_count_ff = 0;
  end

  ////////////////////////////////////////////////////////////////
  // the pulsed line names the bit value
  always @(posedge clk) begin
    if (zeros_in || ones_in) begin
      rx_bits_ff  <= {rx_bits_ff[62:0], ones_in};
      rx_count_ff <= rx_count_ff + 1;
    end
  end

  task automatic send_bit(input logic b);
    zeros_out <= !b;
    ones_out  <= b;
    @(posedge clk);
    zeros_out <= 1'b0;
    ones_out  <= 1'b0;
  endtask : send_bit
endmodule : disc_unit_model

// [sim/disc_link_parity_and_error_flags_bench.sv]
/*
  Bench for the disc link parity block: register access, line
  transmit and receive, error flags and interrupt routing.
  Assumes disc_parity_pkg and the disc unit model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module disc_link_parity_and_error_flags_bench;
  import disc_parity_pkg::*;
  localparam int LIMIT = 20000;
  logic        CLOCK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        S_AXI_RREADY, FRAME_CLEAR_PULSE, STATUS_CLEAR_PULSE, ODD_WRITE_CLOCK;
  logic        SHIFT_STEP_PULSE, PHASE_SET_PULSE, ADDRESS_SENDING_STATE, WORDS_REMAINING_LEVEL;
  logic        ACCUMULATOR_OUT_BIT, DATA_CLOCK_CHAIN, READ_ZERO_PULSE, READ_ONE_PULSE;
  logic        CLEAR_BIT_TWO, ODD_ZEROS_IN, ODD_ONES_IN, ODD_ZEROS_LINE_PULSE;
  logic        ODD_ONES_LINE_PULSE, UNIT_OPERABLE_LEVEL;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, IRQ_REQUEST_LINES;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  int          fail_count, checks, cyc, n_chain, n_rz, n_cb2, n_ro, c;

  disc_parity dut (.CLOCK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .FRAME_CLEAR_PULSE, .STATUS_CLEAR_PULSE,
    .ODD_WRITE_CLOCK, .SHIFT_STEP_PULSE, .PHASE_SET_PULSE, .ADDRESS_SENDING_STATE,
    .WORDS_REMAINING_LEVEL, .ACCUMULATOR_OUT_BIT, .DATA_CLOCK_CHAIN, .READ_ZERO_PULSE,
    .READ_ONE_PULSE, .CLEAR_BIT_TWO, .ODD_ZEROS_IN, .ODD_ONES_IN, .ODD_ZEROS_LINE_PULSE,
    .ODD_ONES_LINE_PULSE, .UNIT_OPERABLE_LEVEL, .IRQ_REQUEST_LINES);
  disc_unit_model u_disc (.clk(CLOCK), .zeros_out(ODD_ZEROS_IN), .ones_out(ODD_ONES_IN),
    .operable(UNIT_OPERABLE_LEVEL), .zeros_in(ODD_ZEROS_LINE_PULSE),
    .ones_in(ODD_ONES_LINE_PULSE));

  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    n_chain += DATA_CLOCK_CHAIN;
    n_rz += READ_ZERO_PULSE;
    n_ro += READ_ONE_PULSE;
    n_cb2 += CLEAR_BIT_TWO;
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick
  // 0 frame clear, 1 status clear, 2 phase set, else write clock
  task automatic strobe(input int k);
    case (k)
      0: FRAME_CLEAR_PULSE <= 1'b1;
      1: STATUS_CLEAR_PULSE <= 1'b1;
      2: PHASE_SET_PULSE <= 1'b1;
      default: ODD_WRITE_CLOCK <= 1'b1;
    endcase
    @(posedge CLOCK);
    {FRAME_CLEAR_PULSE, STATUS_CLEAR_PULSE, PHASE_SET_PULSE, ODD_WRITE_CLOCK} <= 4'h0;
  endtask : strobe
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_AWVALID && !S_AXI_AWREADY || S_AXI_WVALID && !S_AXI_WREADY);
    while (!S_AXI_BVALID) @(posedge CLOCK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge CLOCK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLOCK); while (!S_AXI_RVALID);
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd
  task automatic load(input logic [5:0] v);
    axi_wr(REG_CMDLOAD, {26'h0, v}, rsp);
  endtask : load
  function automatic logic [63:0] msk(input int n);
    return (64'h1 << (n - 1)) - 64'h1;
  endfunction : msk

  ////////////////////////////////////////////////////////////////
  // n counts the parity bit; data goes out high bit first
  task automatic tx_word(input logic [63:0] d, input int n);
    logic [63:0] m;
    m = msk(n);
    strobe(0);
    for (int i = n - 2; i >= 0; i--) begin
      ACCUMULATOR_OUT_BIT <= d[i];
      strobe(3);
      tick(SETTLE_CYCLES + 2);
    end
    strobe(2);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PHASE_BIT], 1'b1)
    `CHK(rd[STAT_PAR_BIT], ^(d & m))
    strobe(3);
    tick(SETTLE_CYCLES + 2);
    `CHK((u_disc.rx_bits_ff >> 1) & m, d & m)
    `CHK(u_disc.rx_bits_ff[0], ~^(d & m))
    `CHK(^(u_disc.rx_bits_ff & ((m << 1) | 64'h1)), 1'b1)
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PAR_BIT], 1'b0)
  endtask : tx_word
  task automatic rx_word(input logic [63:0] d, input int n, input logic bad, input logic rd_cmd);
    logic [63:0] m;
    logic        p;
    int          z, z0, c0, ch0, o0;
    m = msk(n);
    p = ~^(d & m) ^ bad;
    z = n - 1 - $countones(d & m) + int'(!p);
    strobe(0);
    {z0, c0, ch0, o0} = {n_rz, n_cb2, n_chain, n_ro};
    for (int i = n - 2; i >= 0; i--) begin
      u_disc.send_bit(d[i]);
      tick(SETTLE_CYCLES + 4);
    end
    strobe(2);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PAR_BIT], ^(d & m))
    u_disc.send_bit(p);
    tick(SETTLE_CYCLES + 4);
    `CHK(n_rz - z0, z)
    `CHK(n_chain - ch0, n)
    `CHK(n_ro - o0, $countones(d & m) + int'(p))
    `CHK(n_cb2 - c0, rd_cmd ? z : 0)
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PAR_BIT], 1'b0)
  endtask : rx_word

  initial begin
    {CLOCK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 6'h0;
    {S_AXI_RREADY, FRAME_CLEAR_PULSE, STATUS_CLEAR_PULSE, ODD_WRITE_CLOCK} = 4'h0;
    {SHIFT_STEP_PULSE, PHASE_SET_PULSE, ADDRESS_SENDING_STATE} = 3'h0;
    {WORDS_REMAINING_LEVEL, ACCUMULATOR_OUT_BIT} = 2'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {16'h0, 32'h0, 4'hf};
    {fail_count, checks, cyc, n_chain, n_rz, n_cb2, n_ro} = '0;
    tick(10);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd, 32'h0)
    axi_rd(8'h10, rd, rsp);
    `CHK({rsp, rd}, {AXI_SLVERR, 32'h0})
    axi_wr(REG_STATUS, 32'h1f, rsp);
    `CHK(rsp, AXI_SLVERR)
    // unit drops out: flag and request must not wait for a clock
    load({3'd7, 1'b1, CMD_IDLE_C});
    u_disc.operable <= 1'b0;
    #1 `CHK(IRQ_REQUEST_LINES, 8'h80)
    @(posedge CLOCK);
    for (int ch = 0; ch < 8; ch++) begin
      load({ch[2:0], 1'b1, CMD_READ_C});
      `CHK(IRQ_REQUEST_LINES, ch == 0 ? 8'h0 : 8'h1 << ch)
      axi_rd(REG_CTRL, rd, rsp);
      `CHK(rd[5:0], {ch[2:0], 1'b1, CMD_IDLE_C})
    end
    axi_rd(REG_STATUS, rd, rsp);
    `CHK({rd[STAT_NOTOPR_BIT], rd[STAT_FER_BIT]}, 2'h3)
    load({3'd2, 1'b0, CMD_IDLE_C});
    `CHK(IRQ_REQUEST_LINES, 8'h0)
    u_disc.operable <= 1'b1;
    tick(2);
    strobe(1);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[4:0], 5'h0)
    ADDRESS_SENDING_STATE <= 1'b1;
    tx_word(64'hb_5c3e, 21);
    ADDRESS_SENDING_STATE <= 1'b0;
    load({3'd1, 1'b1, CMD_WRITE_C});
    axi_rd(REG_CTRL, rd, rsp);
    `CHK(rd[5:0], {3'd1, 1'b1, CMD_WRITE_C})
    tx_word(64'h8_0000_0001, 37);
    tx_word(64'h1_2345_6789, 37);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PER_BIT], 1'b0)
    WORDS_REMAINING_LEVEL <= 1'b1;
    load({3'd1, 1'b1, CMD_READ_C});
    rx_word(64'h0_f0f0_1234, 37, 1'b0, 1'b1);
    `CHK({rd[STAT_PER_BIT], IRQ_REQUEST_LINES}, 9'h0)
    load({3'd1, 1'b1, CMD_RDCMP_C});
    rx_word(64'h5_5555_aaab, 37, 1'b1, 1'b0);
    `CHK({rd[STAT_PER_BIT], IRQ_REQUEST_LINES}, 9'h102)
    rx_word(64'h0_0000_0007, 37, 1'b0, 1'b0);
    `CHK(rd[STAT_PER_BIT], 1'b1)
    strobe(1);
    axi_rd(REG_STATUS, rd, rsp);
    `CHK(rd[STAT_PER_BIT], 1'b0)
    // count exhausted: incoming pulses must be ignored
    WORDS_REMAINING_LEVEL <= 1'b0;
    c = n_chain;
    u_disc.send_bit(1'b0);
    tick(SETTLE_CYCLES + 4);
    `CHK(n_chain - c, 0)
    final_report();
  end
endmodule : disc_link_parity_and_error_flags_bench
